// *** bench/fri_dp_model.sv ***
// Arithmetic datapath model: fresh random results after every falling edge.
// Assumes the bench clock; values also exist from time zero.
`timescale 1ns/1ps
`default_nettype none

module fri_dp_model (
	// Clock
	input  wire logic               sys_clk,
	// Datapath results
	output var fri_pkg::fri_exp_t   res_exp,
	output logic [10:0]             exp_diff,
	output var fri_pkg::fri_exp_t   rem_exp,
	output logic [47:0]             res_frac,
	output logic                    res_frac_sign,
	output logic                    prod_order_zero,
	output logic                    prod_exp_in_range,
	output var fri_pkg::fri_cmp_t   cmp_res,
	output logic [2:0]              opnd_dflags
);
	int          seed = 22;
	logic [31:0] r;

	initial forever begin
		r = $random(seed);
		// Flags kept rare so sticky bits do not saturate at once
		res_exp = {r[2:0] == 3'h0, r[5:3] == 3'h0, r[6], r[16:7]};
		rem_exp = {r[8:7] == 2'h0, r[9], r[10], r[20:11]};
		exp_diff = r[31] ? 11'h030 + 11'(r[1:0]) : 11'(r[30:21]);
		res_frac = r[23:21] == 3'h0 ? 48'h0 : {r, r[15:0]};
		res_frac_sign = r[24];
		{prod_order_zero, prod_exp_in_range} = r[26:25];
		cmp_res = {r[28:27] == 2'h0, r[28:27] == 2'h1, r[28], r[29]};
		opnd_dflags = r[31:29];
		@(negedge sys_clk);
	end
endmodule // fri_dp_model

`default_nettype wire

// *** bench/fri_indicator_logic_tb_top.sv ***
// Self-checking bench for the result indicator logic.
// Assumes fri_dp_model supplies all datapath results.
`timescale 1ns/1ps
`default_nettype none

module fri_indicator_logic_tb_top;
	logic              sys_clk = 1'b0;
	logic              sys_rst = 1'b1;
	logic              clk_en = 1'b1;
	logic              op_end = 1'b0;
	fri_pkg::fri_op_t  op_kind = fri_pkg::FRI_OP_ADD;
	fri_pkg::fri_exp_t res_exp, rem_exp;
	fri_pkg::fri_cmp_t cmp_res;
	logic [10:0]       exp_diff;
	logic [47:0]       res_frac;
	logic [2:0]        opnd_dflags;
	logic              res_frac_sign, prod_order_zero, prod_exp_in_range, ind_upd, en;
	logic [63:0]       ind_word, mdl, e;
	logic [63:0]       expq[$];
	int                err_total = 0, compares = 0, seed = 22;

	always #50 sys_clk = ~sys_clk;

	fri_dp_model u_fri_dp_model (.sys_clk, .res_exp, .exp_diff, .rem_exp, .res_frac,
		.res_frac_sign, .prod_order_zero, .prod_exp_in_range, .cmp_res, .opnd_dflags);
	fri_indicator_logic u_fri_indicator_logic (.sys_clk, .sys_rst, .clk_en, .op_end, .op_kind,
		.res_exp, .exp_diff, .rem_exp, .res_frac, .res_frac_sign, .prod_order_zero,
		.prod_exp_in_range, .cmp_res, .opnd_dflags, .ind_word, .ind_upd);

	task automatic chk(input string nm, input logic [63:0] ev, input logic [63:0] got);
		compares++;
		if (got !== ev) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, ev, got);
		end
	endtask

	task automatic test_done();
		chk("pending", 64'h0, 64'(expq.size()));
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Expected word from the current inputs and the previous expectation
	task automatic note();
		logic [63:0] n;
		logic        nz, cmp, rng, st, fl;
		n = mdl;
		nz = |res_frac;
		cmp = op_kind >= fri_pkg::FRI_OP_CMP && op_kind <= fri_pkg::FRI_OP_CMP_MAG_RNG;
		rng = op_kind inside {fri_pkg::FRI_OP_CMP_RNG, fri_pkg::FRI_OP_CMP_MAG_RNG};
		st = op_kind >= fri_pkg::FRI_OP_STORE && op_kind <= fri_pkg::FRI_OP_STORE_ROOT;
		fl = res_exp.flag_gen | res_exp.flag_prop;
		if ((op_kind <= fri_pkg::FRI_OP_ADD_MAG_DBL || cmp) && exp_diff > 11'h030
			&& !res_exp.flag_prop) n[27] = 1'b1;
		if (res_exp.flag_prop) n[28] = 1'b1;
		if (res_exp.flag_gen && !res_exp.sign) n[29] = 1'b1;
		if (!fl && !res_exp.sign && res_exp.mag[1]) n[30] = 1'b1;
		if (!fl && !res_exp.sign && !res_exp.mag[1] && |res_exp.mag[2:4]) n[31] = 1'b1;
		if (res_exp.flag_gen && res_exp.sign) n[32] = 1'b1;
		if (op_kind inside {fri_pkg::FRI_OP_MUL, fri_pkg::FRI_OP_MUL_DBL} && prod_order_zero
			&& prod_exp_in_range) n[33] = 1'b1;
		if (op_kind == fri_pkg::FRI_OP_DIV_DBL && rem_exp.flag_gen && rem_exp.sign)
			n[34] = 1'b1;
		if (!st) n[37:35] = opnd_dflags;
		n[55] = op_kind inside {fri_pkg::FRI_OP_ADD_MEM, fri_pkg::FRI_OP_ADD_MAG_MEM};
		if (!cmp) n[59:56] = {res_frac_sign, nz & !res_frac_sign, !nz,
			nz & res_frac_sign};
		else n[62:60] = {cmp_res.acc_greater, rng ? cmp_res.in_range & mdl[62] : cmp_res.acc_equal,
			cmp_res.acc_less & !rng};
		mdl = n;
		expq.push_back(n);
	endtask

	task automatic run(input int cnt);
		repeat (cnt) begin
			@(negedge sys_clk);
			op_end = ({$random(seed)} % 4) != 0;
			clk_en = ({$random(seed)} % 8) != 0;
			op_kind = fri_pkg::fri_op_t'(5'({$random(seed)} % 20));
			#1;
			if (op_end && clk_en) note();
		end
		@(negedge sys_clk);
		op_end = 1'b0;
		clk_en = 1'b1;
	endtask

	task automatic do_reset();
		sys_rst = 1'b1;
		op_end = 1'b0;
		repeat (10) @(negedge sys_clk);
		chk("reset word", 64'h0, ind_word);
		expq.delete();
		mdl = 64'h0;
		sys_rst = 1'b0;
	endtask

	// An update is owed only when the registering edge ran with clk_en high
	always @(posedge sys_clk) begin
		en = clk_en && !sys_rst;
		#1;
		if (en && ind_upd === 1'b1) begin
			e = expq.size() != 0 ? expq.pop_front() : 'x;
			chk("ind_word", e, ind_word);
		end
	end

	initial begin
		do_reset();
		run(400);
		do_reset();
		run(400);
		repeat (3) @(negedge sys_clk);
		test_done();
	end

	initial begin
		#200000;
		err_total++;
		test_done();
	end
endmodule // fri_indicator_logic_tb_top

`default_nettype wire

// *** bench/fri_monitor.sv ***
// Port checker for the result indicator logic.
// Assumes it is bound to fri_indicator_logic and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module fri_monitor #(
	parameter int FRAC_W = 48
) (
	// Clock, reset, operation end
	input wire logic              sys_clk,
	input wire logic              sys_rst,
	input wire logic              clk_en,
	input wire logic              op_end,
	input wire fri_pkg::fri_op_t  op_kind,
	// Datapath results
	input wire fri_pkg::fri_exp_t res_exp,
	input wire logic [FRAC_W-1:0] res_frac,
	input wire logic              res_frac_sign,
	input wire fri_pkg::fri_cmp_t cmp_res,
	input wire logic [2:0]        opnd_dflags,
	// Indicators
	input wire logic [63:0]       ind_word,
	input wire logic              ind_upd
);
	logic go, cmp, rng, st, mem;
	assign go  = op_end && clk_en;
	assign cmp = op_kind >= fri_pkg::FRI_OP_CMP && op_kind <= fri_pkg::FRI_OP_CMP_MAG_RNG;
	assign rng = op_kind == fri_pkg::FRI_OP_CMP_RNG || op_kind == fri_pkg::FRI_OP_CMP_MAG_RNG;
	assign st  = op_kind >= fri_pkg::FRI_OP_STORE && op_kind <= fri_pkg::FRI_OP_STORE_ROOT;
	assign mem = op_kind == fri_pkg::FRI_OP_ADD_MEM || op_kind == fri_pkg::FRI_OP_ADD_MAG_MEM;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	upd_pulse_a: assert property (go |=> ind_upd) else $error("missing update");
	upd_idle_a: assert property (!op_end && clk_en |=> !ind_upd) else $error("stray update");
	// Mask covers the set-only bits 27..34
	sticky_hold_a: assert property (($past(ind_word) & ~ind_word & 64'h0000_0007_f800_0000) == 64'h0)
		else $error("sticky bit fell");
	mem_flag_a: assert property (go |=> ind_word[55] == $past(mem)) else $error("to-memory");
	dflag_copy_a: assert property (go && !st |=> ind_word[37:35] == $past(opnd_dflags))
		else $error("data flags");
	dflag_keep_a: assert property (go && st |=> $stable(ind_word[37:35])) else $error("store");
	frac_zero_a: assert property (go && !cmp && ~|res_frac |=> ind_word[58:56] == 3'h2)
		else $error("zero fraction");
	frac_sign_a: assert property (go && !cmp |=> ind_word[59] == $past(res_frac_sign))
		else $error("sign flag");
	cmp_keep_a: assert property (go && cmp |=> $stable(ind_word[59:56])) else $error("cmp");
	acc_high_a: assert property (go && cmp |=> ind_word[62] == $past(cmp_res.acc_greater))
		else $error("acc high");
	range_low_a: assert property (go && rng |=> !ind_word[60]) else $error("range low");
endmodule // fri_monitor

bind fri_indicator_logic fri_monitor #(.FRAC_W(FRAC_W)) u_fri_monitor (.sys_clk, .sys_rst,
	.clk_en, .op_end, .op_kind, .res_exp, .res_frac, .res_frac_sign, .cmp_res, .opnd_dflags,
	.ind_word, .ind_upd);

`default_nettype wire

// *** design/fri_exp_decode.sv ***
// Exponent condition decode: flag, overflow, range and underflow classes.
// Assumes a settled exponent from the datapath on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "fri_regs.svh"

module fri_exp_decode (
	// Exponent in
	input  wire fri_pkg::fri_exp_t      exp_in,
	// Classes out
	output var fri_pkg::fri_exp_cond_t  cond
);

	logic [`FRI_EXP_LOW_LAST:`FRI_EXP_LOW_FIRST] low_bits;
	logic                                        flag_any;

	genvar g;
	generate
		for (g = `FRI_EXP_LOW_FIRST; g <= `FRI_EXP_LOW_LAST; g++) begin : g_low
			assign low_bits[g] = exp_in.mag[g];
		end
	endgenerate

	// Range classes need the flag clear whichever way it was set
	assign flag_any = exp_in.flag_gen | exp_in.flag_prop;

	always_comb begin
		cond.prop = exp_in.flag_prop;
		cond.ovf  = exp_in.flag_gen & ~exp_in.sign;
		cond.unf  = exp_in.flag_gen & exp_in.sign;
		cond.high = ~flag_any & ~exp_in.sign & exp_in.mag[`FRI_EXP_HI_POS];
		cond.low  = ~flag_any & ~exp_in.sign & ~exp_in.mag[`FRI_EXP_HI_POS]
			& (|low_bits);
	end

endmodule // fri_exp_decode
`default_nettype wire

// *** design/fri_frac_class.sv ***
// Fraction result classification: below, zero, above and sign negative.
// Assumes sign and fraction come from the same settled result.
`timescale 1ns/1ps
`default_nettype none
`include "fri_regs.svh"

module fri_frac_class #(
	parameter int FRAC_W = `FRI_FRAC_W
) (
	// Fraction in
	input  wire logic [FRAC_W-1:0]      frac,
	input  wire logic                   sign,
	// Classes out
	output var fri_pkg::fri_frac_cond_t cond
);

	logic nonzero;

	assign nonzero = |frac;

	always_comb begin
		cond.zero  = ~nonzero;
		cond.below = nonzero & sign;
		cond.above = nonzero & ~sign;
		// Negative zero still counts as negative
		cond.neg   = sign;
	end

endmodule // fri_frac_class
`default_nettype wire

// *** design/fri_indicator_logic.sv ***
// Floating point result indicator logic of the parallel arithmetic unit.
// Assumes all datapath inputs are on sys_clk and stable while op_end is high.
`timescale 1ns/1ps
`default_nettype none
`include "fri_regs.svh"

module fri_indicator_logic #(
	parameter int FRAC_W  = `FRI_FRAC_W,
	parameter int SHIFT_W = `FRI_SHIFT_W
) (
	// Clock, reset and enable
	input  wire logic                    sys_clk,
	input  wire logic                    sys_rst,
	input  wire logic                    clk_en,
	// Operation end and kind
	input  wire logic                    op_end,
	input  wire fri_pkg::fri_op_t        op_kind,
	// Result exponent
	input  wire fri_pkg::fri_exp_t       res_exp,
	input  wire logic [SHIFT_W-1:0]      exp_diff,
	// Remainder exponent, divide double only
	input  wire fri_pkg::fri_exp_t       rem_exp,
	// Fraction result
	input  wire logic [FRAC_W-1:0]       res_frac,
	input  wire logic                    res_frac_sign,
	// Multiply product order zero and exponent net in range
	input  wire logic                    prod_order_zero,
	input  wire logic                    prod_exp_in_range,
	// Compare outcome
	input  wire fri_pkg::fri_cmp_t       cmp_res,
	// Storage operand data flags, t at bit 0
	input  wire logic [`FRI_DFLAG_W-1:0] opnd_dflags,
	// Indicator word and update pulse
	output logic [`FRI_IND_W-1:0]        ind_word,
	output logic                         ind_upd
);

	fri_pkg::fri_state_t     st_ff;
	fri_pkg::fri_state_t     nxt_st;
	fri_pkg::fri_exp_cond_t  res_cond;
	fri_pkg::fri_exp_cond_t  rem_cond;
	fri_pkg::fri_frac_cond_t frac_cond;
	logic                    shift_over;

	// Classes of the kind presented with op_end
	logic                    op_cmp;
	logic                    op_rng;
	logic                    op_add;
	logic                    op_mul;
	logic                    op_divd;
	logic                    op_store;
	logic                    op_tomem;

	// Set-only requests and owned rewrites for the current operation
	logic [`FRI_IND_W-1:0]   set_mask;
	logic [`FRI_IND_W-1:0]   wr_mask;
	logic [`FRI_IND_W-1:0]   wr_val;
	logic [`FRI_IND_W-1:0]   merged;

	// Operation class decodes, each called once below
	function automatic logic is_compare(input fri_pkg::fri_op_t op);
		case (op)
			fri_pkg::FRI_OP_CMP,
			fri_pkg::FRI_OP_CMP_MAG,
			fri_pkg::FRI_OP_CMP_RNG,
			fri_pkg::FRI_OP_CMP_MAG_RNG: is_compare = 1'b1;
			default:                     is_compare = 1'b0;
		endcase
	endfunction

	function automatic logic is_range_cmp(input fri_pkg::fri_op_t op);
		case (op)
			fri_pkg::FRI_OP_CMP_RNG,
			fri_pkg::FRI_OP_CMP_MAG_RNG: is_range_cmp = 1'b1;
			default:                     is_range_cmp = 1'b0;
		endcase
	endfunction

	function automatic logic is_add_type(input fri_pkg::fri_op_t op);
		case (op)
			fri_pkg::FRI_OP_ADD,
			fri_pkg::FRI_OP_ADD_MEM,
			fri_pkg::FRI_OP_ADD_MAG,
			fri_pkg::FRI_OP_ADD_MAG_MEM,
			fri_pkg::FRI_OP_ADD_DBL,
			fri_pkg::FRI_OP_ADD_MAG_DBL: is_add_type = 1'b1;
			default:                     is_add_type = 1'b0;
		endcase
	endfunction

	function automatic logic is_to_memory(input fri_pkg::fri_op_t op);
		case (op)
			fri_pkg::FRI_OP_ADD_MEM,
			fri_pkg::FRI_OP_ADD_MAG_MEM: is_to_memory = 1'b1;
			default:                     is_to_memory = 1'b0;
		endcase
	endfunction

	function automatic logic is_store(input fri_pkg::fri_op_t op);
		case (op)
			fri_pkg::FRI_OP_STORE,
			fri_pkg::FRI_OP_STORE_RND,
			fri_pkg::FRI_OP_STORE_LOW,
			fri_pkg::FRI_OP_STORE_ROOT: is_store = 1'b1;
			default:                    is_store = 1'b0;
		endcase
	endfunction

	function automatic logic is_multiply(input fri_pkg::fri_op_t op);
		case (op)
			fri_pkg::FRI_OP_MUL,
			fri_pkg::FRI_OP_MUL_DBL: is_multiply = 1'b1;
			default:                 is_multiply = 1'b0;
		endcase
	endfunction

	function automatic logic is_div_double(input fri_pkg::fri_op_t op);
		case (op)
			fri_pkg::FRI_OP_DIV_DBL: is_div_double = 1'b1;
			default:                 is_div_double = 1'b0;
		endcase
	endfunction

	// Positions that carry an indicator; every other bit of the word stays zero
	function automatic logic [`FRI_IND_W-1:0] used_bits();
		logic [`FRI_IND_W-1:0] u;
		u = '0;
		u[`FRI_BIT_PRESHIFT]    = 1'b1;
		u[`FRI_BIT_XPROP]       = 1'b1;
		u[`FRI_BIT_XOVF]        = 1'b1;
		u[`FRI_BIT_XHIGH]       = 1'b1;
		u[`FRI_BIT_XLOW]        = 1'b1;
		u[`FRI_BIT_XUNF]        = 1'b1;
		u[`FRI_BIT_ZPROD]       = 1'b1;
		u[`FRI_BIT_REMUNF]      = 1'b1;
		u[`FRI_BIT_DFLAG_HI:`FRI_BIT_DFLAG_LO] = '1;
		u[`FRI_BIT_TOMEM]       = 1'b1;
		u[`FRI_BIT_BELOW]       = 1'b1;
		u[`FRI_BIT_ZERO]        = 1'b1;
		u[`FRI_BIT_ABOVE]       = 1'b1;
		u[`FRI_BIT_NEG]         = 1'b1;
		u[`FRI_BIT_ACC_LESS]    = 1'b1;
		u[`FRI_BIT_ACC_EQUAL]   = 1'b1;
		u[`FRI_BIT_ACC_GREATER] = 1'b1;
		return u;
	endfunction

	localparam logic [`FRI_IND_W-1:0] IND_USED = used_bits();

	fri_exp_decode u_res_exp (
		.exp_in (res_exp),
		.cond   (res_cond)
	);

	// Only generated flag and sign of the remainder matter here
	fri_exp_decode u_rem_exp (
		.exp_in (rem_exp),
		.cond   (rem_cond)
	);

	fri_frac_class #(
		.FRAC_W (FRAC_W)
	) u_frac (
		.frac (res_frac),
		.sign (res_frac_sign),
		.cond (frac_cond)
	);

	assign shift_over = exp_diff > SHIFT_W'(`FRI_SHIFT_LIMIT);

	// Decoded once here so each group below reads plain flags
	assign op_cmp   = is_compare(op_kind);
	assign op_rng   = is_range_cmp(op_kind);
	assign op_add   = is_add_type(op_kind);
	assign op_mul   = is_multiply(op_kind);
	assign op_divd  = is_div_double(op_kind);
	assign op_store = is_store(op_kind);
	assign op_tomem = is_to_memory(op_kind);

	// Set-only indicators; preshift and remainder underflow behave like the sticky group
	always_comb begin
		set_mask = '0;

		if ((op_add || op_cmp) && shift_over && !res_cond.prop) begin
			set_mask[`FRI_BIT_PRESHIFT] = 1'b1;
		end
		if (res_cond.prop) begin
			set_mask[`FRI_BIT_XPROP] = 1'b1;
		end
		if (res_cond.ovf) begin
			set_mask[`FRI_BIT_XOVF] = 1'b1;
		end
		if (res_cond.high) begin
			set_mask[`FRI_BIT_XHIGH] = 1'b1;
		end
		if (res_cond.low) begin
			set_mask[`FRI_BIT_XLOW] = 1'b1;
		end
		if (res_cond.unf) begin
			set_mask[`FRI_BIT_XUNF] = 1'b1;
		end
		if (op_mul && prod_order_zero && prod_exp_in_range) begin
			set_mask[`FRI_BIT_ZPROD] = 1'b1;
		end
		if (op_divd && rem_cond.unf) begin
			set_mask[`FRI_BIT_REMUNF] = 1'b1;
		end
	end

	// Owned indicators: the mask names the bits this kind rewrites, the value what they become
	always_comb begin
		wr_mask = '0;
		wr_val  = '0;

		wr_mask[`FRI_BIT_TOMEM] = 1'b1;
		wr_val[`FRI_BIT_TOMEM]  = op_tomem;

		// Stores keep the previous operand's flags
		if (!op_store) begin
			wr_mask[`FRI_BIT_DFLAG_HI:`FRI_BIT_DFLAG_LO] = '1;
			wr_val[`FRI_BIT_DFLAG_HI:`FRI_BIT_DFLAG_LO]  = opnd_dflags;
		end

		// Fraction group for non-compares, compare group otherwise
		if (!op_cmp) begin
			wr_mask[`FRI_BIT_BELOW] = 1'b1;
			wr_mask[`FRI_BIT_ZERO]  = 1'b1;
			wr_mask[`FRI_BIT_ABOVE] = 1'b1;
			wr_mask[`FRI_BIT_NEG]   = 1'b1;
			wr_val[`FRI_BIT_BELOW]  = frac_cond.below;
			wr_val[`FRI_BIT_ZERO]   = frac_cond.zero;
			wr_val[`FRI_BIT_ABOVE]  = frac_cond.above;
			wr_val[`FRI_BIT_NEG]    = frac_cond.neg;
		end else begin
			wr_mask[`FRI_BIT_ACC_LESS]    = 1'b1;
			wr_mask[`FRI_BIT_ACC_EQUAL]   = 1'b1;
			wr_mask[`FRI_BIT_ACC_GREATER] = 1'b1;
			wr_val[`FRI_BIT_ACC_GREATER]  = cmp_res.acc_greater;
			if (op_rng) begin
				// Range compares never report low
				wr_val[`FRI_BIT_ACC_LESS]  = 1'b0;
				// Equal reads the old high flag, before it is rewritten
				wr_val[`FRI_BIT_ACC_EQUAL] = cmp_res.in_range
					& st_ff.ind[`FRI_BIT_ACC_GREATER];
			end else begin
				wr_val[`FRI_BIT_ACC_LESS]  = cmp_res.acc_less;
				wr_val[`FRI_BIT_ACC_EQUAL] = cmp_res.acc_equal;
			end
		end
	end

	// Owned bits are replaced, set-only bits OR in, the rest hold
	genvar b;
	generate
		for (b = 0; b < `FRI_IND_W; b++) begin : g_merge
			assign merged[b] = IND_USED[b]
				& (wr_mask[b] ? wr_val[b] : (st_ff.ind[b] | set_mask[b]));
		end
	endgenerate

	always_comb begin
		nxt_st     = st_ff;
		nxt_st.upd = 1'b0;
		// Nothing moves until the end cycle, so no partial set is ever seen
		if (op_end) begin
			nxt_st.ind = merged;
			nxt_st.upd = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff.ind <= `FRI_IND_RESET;
			st_ff.upd <= 1'b0;
		end else if (clk_en) begin
			st_ff <= nxt_st;
		end
	end

	assign ind_word = st_ff.ind;
	assign ind_upd  = st_ff.upd;

endmodule // fri_indicator_logic
`default_nettype wire

// *** design/fri_pkg.sv ***
// Types shared by the result indicator logic and its helpers.
// Assumes fri_regs.svh is on the include path.
`default_nettype none
`include "fri_regs.svh"

package fri_pkg;

	typedef enum logic [4:0] {
		FRI_OP_ADD, FRI_OP_ADD_MEM, FRI_OP_ADD_MAG, FRI_OP_ADD_MAG_MEM,
		FRI_OP_ADD_DBL, FRI_OP_ADD_MAG_DBL,
		FRI_OP_CMP, FRI_OP_CMP_MAG, FRI_OP_CMP_RNG, FRI_OP_CMP_MAG_RNG,
		FRI_OP_MUL, FRI_OP_MUL_DBL, FRI_OP_DIV, FRI_OP_DIV_DBL,
		FRI_OP_LOAD, FRI_OP_STORE, FRI_OP_STORE_RND, FRI_OP_STORE_LOW,
		FRI_OP_STORE_ROOT, FRI_OP_OTHER
	} fri_op_t;

	typedef struct packed {
		logic                             flag_gen;
		logic                             flag_prop;
		logic                             sign;
		logic [1:`FRI_EXP_MAG_W]          mag;
	} fri_exp_t;

	typedef struct packed {
		logic prop;
		logic ovf;
		logic high;
		logic low;
		logic unf;
	} fri_exp_cond_t;

	typedef struct packed {
		logic below;
		logic zero;
		logic above;
		logic neg;
	} fri_frac_cond_t;

	typedef struct packed {
		logic acc_less;
		logic acc_equal;
		logic acc_greater;
		logic in_range;
	} fri_cmp_t;

	typedef struct packed {
		logic [`FRI_IND_W-1:0] ind;
		logic                  upd;
	} fri_state_t;

endpackage
`default_nettype wire

// *** design/fri_regs.svh ***
// Indicator positions, limits and reset values for the result indicator logic.
// Assumes the includer works with a 64-bit indicator word, bit n at index n.
`ifndef FRI_REGS_SVH
`define FRI_REGS_SVH

// Indicator positions within the word
`define FRI_BIT_PRESHIFT      27
`define FRI_BIT_XPROP         28
`define FRI_BIT_XOVF          29
`define FRI_BIT_XHIGH         30
`define FRI_BIT_XLOW          31
`define FRI_BIT_XUNF          32
`define FRI_BIT_ZPROD         33
`define FRI_BIT_REMUNF        34
`define FRI_BIT_DFLAG_LO      35
`define FRI_BIT_DFLAG_HI      37
`define FRI_BIT_TOMEM         55
`define FRI_BIT_BELOW         56
`define FRI_BIT_ZERO          57
`define FRI_BIT_ABOVE         58
`define FRI_BIT_NEG           59
`define FRI_BIT_ACC_LESS      60
`define FRI_BIT_ACC_EQUAL     61
`define FRI_BIT_ACC_GREATER   62

// Exponent field layout, magnitude numbered from 1 (highest order)
`define FRI_EXP_MAG_W         10
`define FRI_EXP_HI_POS        1
`define FRI_EXP_LOW_FIRST     2
`define FRI_EXP_LOW_LAST      4

// Limits and widths
`define FRI_SHIFT_LIMIT       48
`define FRI_SHIFT_W           11
`define FRI_FRAC_W            48
`define FRI_IND_W             64
`define FRI_DFLAG_W           3
`define FRI_IND_RESET         64'h0000_0000_0000_0000

`endif
